//--- core/rsd_defines.vh
// Timing, channel and segment constants for the rate sensor digit display
`ifndef RSD_DEFINES_VH
`define RSD_DEFINES_VH
`define RSD_CLK_HZ          50000000
`define RSD_SAMPLE_PERIOD_US 52400
`define RSD_SAMPLE_CYCLES   ((`RSD_SAMPLE_PERIOD_US * 50) / 1)
`define RSD_SCAN_PERIOD_NS  3276800
`define RSD_SCAN_CYCLES     (`RSD_SCAN_PERIOD_NS / 20)
`define RSD_SENSOR_CHANNEL  3'h0
`define RSD_SEG_0           8'h3f
`define RSD_SEG_1           8'h06
`define RSD_SEG_2           8'h5b
`define RSD_SEG_3           8'h4f
`define RSD_SEG_4           8'h66
`define RSD_SEG_5           8'h6d
`define RSD_SEG_6           8'h7d
`define RSD_SEG_7           8'h27
`define RSD_SEG_8           8'h7f
`define RSD_SEG_9           8'h6f
`define RSD_SEG_MINUS       8'h40
`define RSD_SEG_DOT         8'h80
`define RSD_SEG_BLANK       8'h00
`endif

//--- core/rsd_display.v
// Rate sensor sampler, decimal conversion and four-digit scanned display
//
// Operation
// - A conversion of the sensor channel starts once per sampling timer overflow, about 52.4 ms.
// - Completion is taken from the next sampling overflow, not a converter-done signal.
// - The converter channel is fixed at channel 0.
// - The four digits are lit in turn, advancing every 3.2768 ms on a scan timer overflow.
// - Digit select is a two-bit code for an external 2-to-4 decoder.
// - Eight shared segment outputs light a segment when high.
// - Each 10-bit result becomes a signed decimal deg/sec value held for the scanner.
// - A result equal to the reference shows as zero with dots before the last zero.
// - A result below the reference shows its magnitude with a leading minus sign.
// - On each sampling event after the first, the latest result is converted and stored as display data.
// - On each scan event the next digit pattern and select code are presented.
`timescale 1ns/1ns
`default_nettype none
`include "rsd_defines.vh"
module rsd_display #(
   parameter integer SAMPLE_CYCLES = `RSD_SAMPLE_CYCLES,
   parameter integer SCAN_CYCLES   = `RSD_SCAN_CYCLES,
   parameter integer REF_CODE      = 419,
   parameter integer SCALE_NUM     = 1,
   parameter integer SCALE_DEN     = 1
) (
   input  wire       I_CLK,
   input  wire       I_RESETN,
   input  wire [9:0] I_ADC_RESULT,
   output reg        O_ADC_START,
   output wire [2:0] O_ADC_CHANNEL,
   output reg  [7:0] O_SEGMENT,
   output reg  [1:0] O_DIGIT_SELECT
);
   wire       sample_tick;
   wire       scan_tick;
   reg        sample_ready;
   reg  [7:0] disp0;
   reg  [7:0] disp1;
   reg  [7:0] disp2;
   reg  [7:0] disp3;
   reg  [1:0] scan_idx;
   reg        neg;
   reg [31:0] diff;
   reg [31:0] next_mag;
   reg [15:0] mag;
   reg [15:0] rem0;
   reg [15:0] rem1;
   reg [15:0] quo2;
   reg  [1:0] next_idx;

   reg  [3:0] d0;
   reg  [3:0] d1;
   reg  [3:0] d2;
   reg  [7:0] next_disp0;
   reg  [7:0] next_disp1;
   reg  [7:0] next_disp2;
   reg  [7:0] next_disp3;
   reg  [7:0] next_seg;

   assign O_ADC_CHANNEL = `RSD_SENSOR_CHANNEL;

   rsd_timer #(.PERIOD(SAMPLE_CYCLES)) u_sample_timer (
      .i_clk    (I_CLK),
      .i_resetn (I_RESETN),
      .o_tick   (sample_tick)
   );

   rsd_timer #(.PERIOD(SCAN_CYCLES)) u_scan_timer (
      .i_clk    (I_CLK),
      .i_resetn (I_RESETN),
      .o_tick   (scan_tick)
   );

   function [7:0] seg_of;
      input [3:0] d;
      begin
         case (d)
            4'h0: seg_of = `RSD_SEG_0;
            4'h1: seg_of = `RSD_SEG_1;
            4'h2: seg_of = `RSD_SEG_2;
            4'h3: seg_of = `RSD_SEG_3;
            4'h4: seg_of = `RSD_SEG_4;
            4'h5: seg_of = `RSD_SEG_5;
            4'h6: seg_of = `RSD_SEG_6;
            4'h7: seg_of = `RSD_SEG_7;
            4'h8: seg_of = `RSD_SEG_8;
            4'h9: seg_of = `RSD_SEG_9;
            default: seg_of = `RSD_SEG_BLANK;
         endcase
      end
   endfunction

   // Distance from the resting level, kept 32 bits wide so the scale product cannot wrap
   always @* begin
      neg = ({22'h0, I_ADC_RESULT} < REF_CODE);
      if (neg) begin
         diff = REF_CODE - {22'h0, I_ADC_RESULT};
      end else begin
         diff = {22'h0, I_ADC_RESULT} - REF_CODE;
      end
      next_mag = diff * SCALE_NUM / SCALE_DEN;
   end

   // Three digits only; larger magnitudes saturate at 999
   always @* begin
      if (next_mag > 32'd999) begin
         mag = 16'd999;
      end else begin
         mag = next_mag[15:0];
      end
   end

   // Constant divisors, so the digit split stays combinational
   always @* begin
      rem0 = mag % 16'd10;
      rem1 = (mag / 16'd10) % 16'd10;
      quo2 = mag / 16'd100;
      d0   = rem0[3:0];
      d1   = rem1[3:0];
      d2   = quo2[3:0];
   end

   // Units always show a numeral, so a resting input reads as zero
   always @* begin
      next_disp0 = seg_of(d0);
   end

   // Tens: numeral, a minus for a small negative value, or a dot as filler
   always @* begin
      if (mag >= 16'd10) begin
         next_disp1 = seg_of(d1);
      end else if (neg) begin
         next_disp1 = `RSD_SEG_MINUS;
      end else begin
         next_disp1 = `RSD_SEG_DOT;
      end
   end

   // Hundreds: numeral, a minus for a two-digit negative value, or a dot
   always @* begin
      if (mag >= 16'd100) begin
         next_disp2 = seg_of(d2);
      end else if (neg && mag >= 16'd10) begin
         next_disp2 = `RSD_SEG_MINUS;
      end else begin
         next_disp2 = `RSD_SEG_DOT;
      end
   end

   // Sign position only carries a minus when all three numerals are in use
   always @* begin
      if (neg && mag >= 16'd100) begin
         next_disp3 = `RSD_SEG_MINUS;
      end else begin
         next_disp3 = `RSD_SEG_DOT;
      end
   end

   // Start pulse follows every overflow by one cycle
   always @(posedge I_CLK) begin
      if (!I_RESETN) begin
         O_ADC_START <= 1'b0;
      end else begin
         O_ADC_START <= sample_tick;
      end
   end

   // Each overflow stores the previous conversion; the first one has nothing to store
   always @(posedge I_CLK) begin
      if (!I_RESETN) begin
         sample_ready <= 1'b0;
         disp0        <= `RSD_SEG_0;
         disp1        <= `RSD_SEG_DOT;
         disp2        <= `RSD_SEG_DOT;
         disp3        <= `RSD_SEG_DOT;
      end else if (sample_tick) begin
         sample_ready <= 1'b1;
         if (sample_ready) begin
            disp0 <= next_disp0;
            disp1 <= next_disp1;
            disp2 <= next_disp2;
            disp3 <= next_disp3;
         end
      end
   end

   always @* begin
      next_idx = scan_idx + 2'h1;
   end

   always @* begin
      case (next_idx)
         2'h0: next_seg = disp0;
         2'h1: next_seg = disp1;
         2'h2: next_seg = disp2;
         2'h3: next_seg = disp3;
         default: next_seg = `RSD_SEG_BLANK;
      endcase
   end

   // Segments and select change together so no digit shows a neighbour's pattern
   always @(posedge I_CLK) begin
      if (!I_RESETN) begin
         scan_idx       <= 2'h0;
         O_SEGMENT      <= `RSD_SEG_BLANK;
         O_DIGIT_SELECT <= 2'h0;
      end else if (scan_tick) begin
         scan_idx       <= next_idx;
         O_SEGMENT      <= next_seg;
         O_DIGIT_SELECT <= next_idx;
      end
   end
endmodule
`default_nettype wire

//--- core/rsd_timer.v
// Free-running period timer giving a one-cycle overflow pulse
`timescale 1ns/1ns
`default_nettype none
module rsd_timer #(
   parameter integer PERIOD = 163840
) (
   input  wire       i_clk,
   input  wire       i_resetn,
   output reg        o_tick
);
   reg [31:0] count;
   always @(posedge i_clk) begin
      if (!i_resetn) begin
         count  <= 32'h0;
         o_tick <= 1'b0;
      end else if (count == PERIOD - 1) begin
         count  <= 32'h0;
         o_tick <= 1'b1;
      end else begin
         count  <= count + 32'h1;
         o_tick <= 1'b0;
      end
   end
endmodule
`default_nettype wire

//--- dv/rate_sensor_digit_display_test.sv
// Self-checking bench for the display block
`timescale 1ns/1ns
`default_nettype none
module rate_sensor_digit_display_test;
   logic       clk = 1'b0, resetn = 1'b0, start;
   logic [9:0] res, code = 10'h1a3, st = 10'h1a3;
   logic [2:0] chan;
   logic [7:0] seg;
   logic [1:0] sel, psel = 2'h0;
   logic [31:0] lf = 32'h67f3;
   logic [9:0] tab [8] = '{10'h1a3, 10'h28d, 10'h0f1, 10'h3ff, 10'h000, 10'h190, 10'h1ae,
                           10'h19e};
   logic [7:0] pt [10] = '{8'h3f, 8'h06, 8'h5b, 8'h4f, 8'h66, 8'h6d, 8'h7d, 8'h27, 8'h7f, 8'h6f};
   int         err_total = 0, total_checks = 0, cyc = 0, ns = 0, sn = 0;
   always #10 clk = ~clk;
   rsd_display #(.SAMPLE_CYCLES(20), .SCAN_CYCLES(3)) uut (.I_CLK(clk), .I_RESETN(resetn),
      .I_ADC_RESULT(res), .O_ADC_START(start), .O_ADC_CHANNEL(chan), .O_SEGMENT(seg),
      .O_DIGIT_SELECT(sel));
   rsd_adc_model adc (.i_clk(clk), .i_start(start), .i_channel(chan), .i_code(code),
      .o_result(res));
   function automatic logic [7:0] ex(logic [1:0] i, logic [9:0] c);
      int v, m;
      v = int'(c) - 419;
      m = v < 0 ? -v : v;
      case (i)
         2'h0: return pt[m % 10];
         2'h1: return m < 10 ? (v < 0 ? 8'h40 : 8'h80) : pt[m / 10 % 10];
         2'h2: return m < 10 ? 8'h80 : m < 100 ? (v < 0 ? 8'h40 : 8'h80) : pt[m / 100];
         default: return m > 99 && v < 0 ? 8'h40 : 8'h80;
      endcase
   endfunction
   task automatic chk(logic [7:0] g, e);
      total_checks++;
      if (g !== e) begin
         err_total++;
         $display("mismatch %0t %h %h", $time, g, e);
      end
   endtask
   task automatic results;
      if (err_total == 0 && total_checks > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask
   // Small negative values put the minus next to the units digit
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == 3) resetn <= 1'b1;
      if (cyc > 1500) begin
         err_total++;
         results();
      end
      if (resetn && start) begin
         ns <= ns + 1;
         sn <= 0;
         if (ns > 0) st <= res;
         lf <= {lf[30:0], lf[31] ^ lf[21] ^ lf[1] ^ lf[0]};
         code <= ns < 8 ? tab[ns] : lf[9:0];
         if (ns == 40) results();
      end else begin
         sn <= sn + 1;
      end
      psel <= sel;
      // Near a sample update old and new data race, so only mid-period scans are judged
      if (resetn && sel != psel && sn > 3 && sn < 16) chk(seg, ex(sel, st));
   end
endmodule
`default_nettype wire

//--- dv/rsd_adc_model.sv
// Converter model answering each start with the queued code
`timescale 1ns/1ns
`default_nettype none
module rsd_adc_model (
   input  wire logic       i_clk,
   input  wire logic       i_start,
   input  wire logic [2:0] i_channel,
   input  wire logic [9:0] i_code,
   output var  logic [9:0] o_result
);
   initial o_result = 10'h1a3;
   // A wrong channel returns the inverse of the last result, so it cannot pass unseen
   always @(posedge i_clk) begin
      if (i_start) begin
         o_result <= i_channel == 3'h0 ? i_code : ~o_result;
      end
   end
endmodule
`default_nettype wire

//--- dv/rsd_sva.sv
// Port assertions for the display block
`timescale 1ns/1ns
`default_nettype none
module rsd_sva #(parameter int SAMPLE_CYCLES = 20, parameter int SCAN_CYCLES = 3) (
   input wire logic       I_CLK,
   input wire logic       I_RESETN,
   input wire logic       O_ADC_START,
   input wire logic [2:0] O_ADC_CHANNEL,
   input wire logic [7:0] O_SEGMENT,
   input wire logic [1:0] O_DIGIT_SELECT
);
   default clocking @(posedge I_CLK); endclocking
   default disable iff (!I_RESETN);
   sequence s_pulse; O_ADC_START ##1 !O_ADC_START; endsequence
   sequence s_step; $changed(O_DIGIT_SELECT); endsequence
   property p_chan; O_ADC_CHANNEL == 3'h0; endproperty
   property p_pulse; O_ADC_START |-> s_pulse; endproperty
   property p_rate; O_ADC_START |-> ##SAMPLE_CYCLES O_ADC_START; endproperty
   property p_scan; s_step |-> ##SCAN_CYCLES s_step; endproperty
   property p_code; s_step |-> O_DIGIT_SELECT == $past(O_DIGIT_SELECT) + 2'h1; endproperty
   property p_seg; $changed(O_SEGMENT) |-> s_step; endproperty
   property p_dot; O_SEGMENT[7] |-> O_SEGMENT[6:0] == 7'h00; endproperty
   // Reset itself must clear the outputs, so this one is never disabled
   property p_rst; disable iff (1'b0)
      !I_RESETN |=> O_SEGMENT == 8'h00 && O_DIGIT_SELECT == 2'h0 && !O_ADC_START; endproperty
   a_chan: assert property (p_chan) else $error("channel");
   a_pulse: assert property (p_pulse) else $error("start width");
   a_rate: assert property (p_rate) else $error("start period");
   a_scan: assert property (p_scan) else $error("scan period");
   a_code: assert property (p_code) else $error("select order");
   a_seg: assert property (p_seg) else $error("segment moved");
   a_dot: assert property (p_dot) else $error("dot pattern");
   a_rst: assert property (p_rst) else $error("reset outputs");
endmodule
bind rsd_display rsd_sva #(.SAMPLE_CYCLES(SAMPLE_CYCLES), .SCAN_CYCLES(SCAN_CYCLES)) u_sva (
   .I_CLK(I_CLK), .I_RESETN(I_RESETN), .O_ADC_START(O_ADC_START),
   .O_ADC_CHANNEL(O_ADC_CHANNEL), .O_SEGMENT(O_SEGMENT), .O_DIGIT_SELECT(O_DIGIT_SELECT));
`default_nettype wire
